// ### cpu_regfile_pkg.sv
// Purpose: Shared constants for the CPU register file block
// Assumes: 32-bit datapath, register numbers are 5 bits wide
// Notes:   Numbers below are the system register numbers used by the
//          load/store system-register instructions
//
// Notes on behaviour
// - General register zero always reads zero
// - Thirty-two general registers, numbered zero to 31
// - PC bits 31..26 zero, carry discarded
// - PC bit zero always held zero
// - System registers selected by fixed register numbers
// - Exception source is read only
// - Debug save registers usable only inside debug
// - Restored saved PC drops bit zero
// - Maskable entry saves PC and status word
// - Saved PC is the next instruction address
// - NMI entry saves into NMI registers only
// - Interrupt save registers upper bits read zero
// - NMI save registers upper bits read zero
// - Interrupt return restores from interrupt save registers
// - NMI return restores from NMI save registers
// - Maskable and NMI entry load exception source code
// - Every register is thirty-two bits wide
// - NMI entry sets status bit seven
// - Status load takes effect right after instruction

package cpu_regfile_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int XLEN  = 32;
   localparam int NGPR  = 32;
   localparam int SEL_W = 5;

   // ----------------------------------------------------------------
   // System register numbers
   // ----------------------------------------------------------------
   localparam logic [4:0] SR_INTR_PC   = 5'h00;
   localparam logic [4:0] SR_INTR_ST   = 5'h01;
   localparam logic [4:0] SR_NMI_PC    = 5'h02;
   localparam logic [4:0] SR_NMI_ST    = 5'h03;
   localparam logic [4:0] SR_EXC_SRC   = 5'h04;
   localparam logic [4:0] SR_STATUS    = 5'h05;
   localparam logic [4:0] SR_TC_PC     = 5'h10;
   localparam logic [4:0] SR_TC_ST     = 5'h11;
   localparam logic [4:0] SR_DBG_PC    = 5'h12;
   localparam logic [4:0] SR_DBG_ST    = 5'h13;
   localparam logic [4:0] SR_TC_BASE   = 5'h14;

   // ----------------------------------------------------------------
   // Masks and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] PC_MASK       = 32'h03FF_FFFE;
   localparam logic [31:0] SAVED_PC_MASK = 32'h03FF_FFFF;
   localparam logic [31:0] STATUS_MASK   = 32'h0000_00FF;
   localparam logic [31:0] STATUS_RESET  = 32'h0000_0020;
   localparam logic [31:0] PC_RESET      = 32'h0000_0000;
   localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
   localparam int          NMI_BIT       = 7;

endpackage

// ### gpr_bank.sv
// Purpose: General-purpose register bank, two read ports, one write port
// Assumes: Reads are registered, one cycle of latency
// Notes:   A read in the write cycle returns the old value

`timescale 1ns/1ps

module gpr_bank #(
   parameter int WIDTH = cpu_regfile_pkg::XLEN,
   parameter int DEPTH = cpu_regfile_pkg::NGPR
) (
   input  wire logic                     sys_clk_in,
   input  wire logic                     resetn_in,
   input  wire logic [$clog2(DEPTH)-1:0] rd_a_sel_in,
   input  wire logic [$clog2(DEPTH)-1:0] rd_b_sel_in,
   input  wire logic                     wr_en_in,
   input  wire logic [$clog2(DEPTH)-1:0] wr_sel_in,
   input  wire logic [WIDTH-1:0]         wr_data_in,
   output logic      [WIDTH-1:0]         rd_a_out,
   output logic      [WIDTH-1:0]         rd_b_out
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
      $error("gpr_bank needs at least two registers");
   end

   // Entry zero has no storage: it is the constant zero
   typedef struct packed {
      logic [DEPTH-1:1][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rd_a;
      logic [WIDTH-1:0]            rd_b;
   } bank_s;

   bank_s bank_reg;
   bank_s bank_next;

   // Read zero for entry zero, writes there are dropped
   always_comb begin
      bank_next = bank_reg;
      bank_next.rd_a = (rd_a_sel_in == '0) ? '0 : bank_reg.mem[rd_a_sel_in];
      bank_next.rd_b = (rd_b_sel_in == '0) ? '0 : bank_reg.mem[rd_b_sel_in];
      if (wr_en_in && wr_sel_in != '0) begin
         bank_next.mem[wr_sel_in] = wr_data_in;
      end
   end

   // State register
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bank_reg <= '0;
      end else begin
         bank_reg <= bank_next;
      end
   end

   assign rd_a_out = bank_reg.rd_a;
   assign rd_b_out = bank_reg.rd_b;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_zero_reads_zero;
      @(posedge sys_clk_in) disable iff (!resetn_in)
      (rd_a_sel_in == '0) |=> (rd_a_out == '0);
   endproperty
   a_zero_reads_zero: assert property (p_zero_reads_zero)
      else $error("register zero read nonzero");

   property p_write_then_read;
      @(posedge sys_clk_in) disable iff (!resetn_in)
      (wr_en_in && wr_sel_in != '0) ##1 (rd_b_sel_in == $past(wr_sel_in) && !wr_en_in)
         |=> (rd_b_out == $past(wr_data_in, 2));
   endproperty
   a_write_then_read: assert property (p_write_then_read)
      else $error("written register did not read back");

   c_write_zero: cover property (@(posedge sys_clk_in) wr_en_in && wr_sel_in == '0);

endmodule

// ### cpu_regfile.sv
// Purpose: CPU register file: general registers, PC and system registers
// Assumes: Pipeline drives one-cycle command pulses on sys_clk_in
// Notes:   Same-cycle priority, lowest first: PC update, flag update,
//          system load, debug entry, debug return, return, maskable, NMI

`timescale 1ns/1ps

module cpu_regfile (
   input  wire logic        sys_clk_in,
   input  wire logic        resetn_in,
   // General registers
   input  wire logic [4:0]  gpr_rd_a_sel_in,
   input  wire logic [4:0]  gpr_rd_b_sel_in,
   input  wire logic        gpr_wr_en_in,
   input  wire logic [4:0]  gpr_wr_sel_in,
   input  wire logic [31:0] gpr_wr_data_in,
   output logic      [31:0] gpr_rd_a_out,
   output logic      [31:0] gpr_rd_b_out,
   // Program counter
   input  wire logic        pc_load_en_in,
   input  wire logic [31:0] pc_load_value_in,
   input  wire logic        pc_advance_en_in,
   input  wire logic [31:0] pc_advance_in,
   output logic      [31:0] pc_out,
   // Status flags from the execute stage
   input  wire logic        status_wr_en_in,
   input  wire logic [31:0] status_wr_in,
   output logic      [31:0] status_word_out,
   // System register load and store
   input  wire logic [4:0]  sysreg_sel_in,
   input  wire logic        sysreg_load_instr_in,
   input  wire logic [31:0] sysreg_load_data_in,
   input  wire logic        sysreg_store_instr_in,
   output logic      [31:0] sysreg_rd_data_out,
   output logic             sysreg_rd_valid_out,
   output logic             sysreg_access_error_out,
   // Exception entry and return
   input  wire logic        maskable_take_in,
   input  wire logic        nmi_take_in,
   input  wire logic [31:0] exc_code_in,
   input  wire logic        interrupt_return_instr_in,
   input  wire logic        debug_trap_instr_in,
   input  wire logic        debug_return_instr_in,
   output logic             debug_active_out,
   output logic      [31:0] table_call_base_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] pc;
      logic [31:0] status;
      logic [31:0] intr_saved_pc;
      logic [31:0] intr_saved_status;
      logic [31:0] nmi_saved_pc;
      logic [31:0] nmi_saved_status;
      logic [31:0] exception_source;
      logic [31:0] table_call_saved_pc;
      logic [31:0] table_call_saved_status;
      logic [31:0] debug_saved_pc;
      logic [31:0] debug_saved_status;
      logic [31:0] table_call_base;
      logic        debug_active;
      logic [31:0] rd_data;
      logic        rd_valid;
      logic        err;
   } regs_s;

   regs_s regs_reg;
   regs_s regs_next;

   // Decides whether a number may be accessed now; debug pair gated
   function automatic logic sysreg_ok(input logic [4:0] sel, input logic dbg);
      unique case (sel)
         cpu_regfile_pkg::SR_INTR_PC, cpu_regfile_pkg::SR_INTR_ST,
         cpu_regfile_pkg::SR_NMI_PC,  cpu_regfile_pkg::SR_NMI_ST,
         cpu_regfile_pkg::SR_EXC_SRC, cpu_regfile_pkg::SR_STATUS,
         cpu_regfile_pkg::SR_TC_PC,   cpu_regfile_pkg::SR_TC_ST,
         cpu_regfile_pkg::SR_TC_BASE: sysreg_ok = 1'b1;
         cpu_regfile_pkg::SR_DBG_PC,
         cpu_regfile_pkg::SR_DBG_ST:  sysreg_ok = dbg;
         default:                     sysreg_ok = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // General-purpose register bank
   // ----------------------------------------------------------------
   gpr_bank #(
      .WIDTH (cpu_regfile_pkg::XLEN),
      .DEPTH (cpu_regfile_pkg::NGPR)
   ) u_gpr_bank (
      .sys_clk_in  (sys_clk_in),
      .resetn_in   (resetn_in),
      .rd_a_sel_in (gpr_rd_a_sel_in),
      .rd_b_sel_in (gpr_rd_b_sel_in),
      .wr_en_in    (gpr_wr_en_in),
      .wr_sel_in   (gpr_wr_sel_in),
      .wr_data_in  (gpr_wr_data_in),
      .rd_a_out    (gpr_rd_a_out),
      .rd_b_out    (gpr_rd_b_out)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Later statements win; reads see the values before this cycle
   always_comb begin
      regs_next          = regs_reg;
      regs_next.rd_valid = 1'b0;
      regs_next.err      = 1'b0;

      // Masking drops the carry into bit 26 and keeps bit 0 clear
      if (pc_load_en_in) begin
         regs_next.pc = pc_load_value_in & cpu_regfile_pkg::PC_MASK;
      end else if (pc_advance_en_in) begin
         regs_next.pc = (regs_reg.pc + pc_advance_in) & cpu_regfile_pkg::PC_MASK;
      end

      if (status_wr_en_in) begin
         regs_next.status = status_wr_in & cpu_regfile_pkg::STATUS_MASK;
      end

      // System register load; exception source and illegal numbers refused
      if (sysreg_load_instr_in) begin
         if (!sysreg_ok(sysreg_sel_in, regs_reg.debug_active) ||
             sysreg_sel_in == cpu_regfile_pkg::SR_EXC_SRC) begin
            regs_next.err = 1'b1;
         end else begin
            unique case (sysreg_sel_in)
               cpu_regfile_pkg::SR_INTR_PC: regs_next.intr_saved_pc =
                  sysreg_load_data_in & cpu_regfile_pkg::SAVED_PC_MASK;
               cpu_regfile_pkg::SR_INTR_ST: regs_next.intr_saved_status =
                  sysreg_load_data_in & cpu_regfile_pkg::STATUS_MASK;
               cpu_regfile_pkg::SR_NMI_PC: regs_next.nmi_saved_pc =
                  sysreg_load_data_in & cpu_regfile_pkg::SAVED_PC_MASK;
               cpu_regfile_pkg::SR_NMI_ST: regs_next.nmi_saved_status =
                  sysreg_load_data_in & cpu_regfile_pkg::STATUS_MASK;
               cpu_regfile_pkg::SR_STATUS: regs_next.status =
                  sysreg_load_data_in & cpu_regfile_pkg::STATUS_MASK;
               cpu_regfile_pkg::SR_TC_PC:   regs_next.table_call_saved_pc = sysreg_load_data_in;
               cpu_regfile_pkg::SR_TC_ST:   regs_next.table_call_saved_status =
                  sysreg_load_data_in;
               cpu_regfile_pkg::SR_DBG_PC:  regs_next.debug_saved_pc = sysreg_load_data_in;
               cpu_regfile_pkg::SR_DBG_ST:  regs_next.debug_saved_status = sysreg_load_data_in;
               default:                     regs_next.table_call_base = sysreg_load_data_in;
            endcase
         end
      end

      // System register store; refused reads return zero
      if (sysreg_store_instr_in) begin
         regs_next.rd_data = '0;
         if (!sysreg_ok(sysreg_sel_in, regs_reg.debug_active)) begin
            regs_next.err = 1'b1;
         end else begin
            regs_next.rd_valid = 1'b1;
            unique case (sysreg_sel_in)
               cpu_regfile_pkg::SR_INTR_PC: regs_next.rd_data = regs_reg.intr_saved_pc;
               cpu_regfile_pkg::SR_INTR_ST: regs_next.rd_data = regs_reg.intr_saved_status;
               cpu_regfile_pkg::SR_NMI_PC:  regs_next.rd_data = regs_reg.nmi_saved_pc;
               cpu_regfile_pkg::SR_NMI_ST:  regs_next.rd_data = regs_reg.nmi_saved_status;
               cpu_regfile_pkg::SR_EXC_SRC: regs_next.rd_data = regs_reg.exception_source;
               cpu_regfile_pkg::SR_STATUS:  regs_next.rd_data = regs_reg.status;
               cpu_regfile_pkg::SR_TC_PC:   regs_next.rd_data = regs_reg.table_call_saved_pc;
               cpu_regfile_pkg::SR_TC_ST:   regs_next.rd_data = regs_reg.table_call_saved_status;
               cpu_regfile_pkg::SR_DBG_PC:  regs_next.rd_data = regs_reg.debug_saved_pc;
               cpu_regfile_pkg::SR_DBG_ST:  regs_next.rd_data = regs_reg.debug_saved_status;
               default:                     regs_next.rd_data = regs_reg.table_call_base;
            endcase
         end
      end

      // Debug trap opens the window for the debug save pair
      if (debug_trap_instr_in) begin
         regs_next.debug_saved_pc     = regs_reg.pc;
         regs_next.debug_saved_status = regs_reg.status;
         regs_next.debug_active       = 1'b1;
      end
      if (debug_return_instr_in) begin
         regs_next.pc           = regs_reg.debug_saved_pc & cpu_regfile_pkg::PC_MASK;
         regs_next.status       = regs_reg.debug_saved_status & cpu_regfile_pkg::STATUS_MASK;
         regs_next.debug_active = 1'b0;
      end

      // Return: the NMI set while NMI is in service, else the interrupt set
      if (interrupt_return_instr_in) begin
         if (regs_reg.status[cpu_regfile_pkg::NMI_BIT]) begin
            regs_next.pc     = regs_reg.nmi_saved_pc & cpu_regfile_pkg::PC_MASK;
            regs_next.status = regs_reg.nmi_saved_status;
         end else begin
            regs_next.pc     = regs_reg.intr_saved_pc & cpu_regfile_pkg::PC_MASK;
            regs_next.status = regs_reg.intr_saved_status;
         end
      end

      // Pipeline has already stepped PC to the next instruction here
      if (maskable_take_in) begin
         regs_next.intr_saved_pc     =
            regs_reg.pc & cpu_regfile_pkg::SAVED_PC_MASK;
         regs_next.intr_saved_status = regs_reg.status;
         regs_next.exception_source  = exc_code_in;
      end

      // NMI last so its code wins a same-cycle collision
      if (nmi_take_in) begin
         regs_next.nmi_saved_pc     =
            regs_reg.pc & cpu_regfile_pkg::SAVED_PC_MASK;
         regs_next.nmi_saved_status = regs_reg.status;
         regs_next.exception_source = exc_code_in;
         regs_next.status[cpu_regfile_pkg::NMI_BIT] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         regs_reg        <= '0;
         regs_reg.pc     <= cpu_regfile_pkg::PC_RESET;
         regs_reg.status <= cpu_regfile_pkg::STATUS_RESET;
      end else begin
         regs_reg <= regs_next;
      end
   end

   // Outputs straight from the state register
   assign pc_out                  = regs_reg.pc;
   assign status_word_out         = regs_reg.status;
   assign sysreg_rd_data_out      = regs_reg.rd_data;
   assign sysreg_rd_valid_out     = regs_reg.rd_valid;
   assign sysreg_access_error_out = regs_reg.err;
   assign debug_active_out        = regs_reg.debug_active;
   assign table_call_base_out     = regs_reg.table_call_base;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   logic quiet;
   assign quiet = !nmi_take_in && !maskable_take_in && !debug_return_instr_in
                  && !interrupt_return_instr_in && !debug_trap_instr_in;

   property p_pc_high_zero;
      pc_out[31:26] == 6'h00;
   endproperty
   a_pc_high_zero: assert property (p_pc_high_zero)
      else $error("PC upper bits not zero");

   property p_pc_even;
      !pc_out[0];
   endproperty
   a_pc_even: assert property (p_pc_even)
      else $error("PC bit zero set");

   property p_src_read_only;
      sysreg_load_instr_in && sysreg_sel_in == cpu_regfile_pkg::SR_EXC_SRC && quiet
         |=> $stable(regs_reg.exception_source) && sysreg_access_error_out;
   endproperty
   a_src_read_only: assert property (p_src_read_only)
      else $error("source register changed by load");

   property p_intr_save;
      maskable_take_in && !nmi_take_in
         |=> regs_reg.intr_saved_pc == ($past(pc_out) & cpu_regfile_pkg::SAVED_PC_MASK)
             && regs_reg.intr_saved_status == $past(status_word_out)
             && regs_reg.exception_source == $past(exc_code_in);
   endproperty
   a_intr_save: assert property (p_intr_save)
      else $error("maskable entry save wrong");

   property p_nmi_save;
      nmi_take_in && !maskable_take_in
         |=> $stable(regs_reg.intr_saved_pc) && status_word_out[7]
             && regs_reg.nmi_saved_pc == $past(pc_out);
   endproperty
   a_nmi_save: assert property (p_nmi_save)
      else $error("NMI entry save wrong");

   property p_saved_high_zero;
      regs_reg.intr_saved_pc[31:26] == 6'h00 && regs_reg.nmi_saved_pc[31:26] == 6'h00
      && regs_reg.intr_saved_status[31:8] == 24'h00_0000
      && regs_reg.nmi_saved_status[31:8] == 24'h00_0000;
   endproperty
   a_saved_high_zero: assert property (p_saved_high_zero)
      else $error("saved register upper bits set");

   property p_return_select;
      interrupt_return_instr_in && !nmi_take_in && !maskable_take_in
         |=> pc_out == (($past(status_word_out[7]) ? $past(regs_reg.nmi_saved_pc)
                         : $past(regs_reg.intr_saved_pc)) & cpu_regfile_pkg::PC_MASK);
   endproperty
   a_return_select: assert property (p_return_select)
      else $error("return restored wrong PC");

   property p_debug_gate;
      sysreg_store_instr_in && sysreg_sel_in == cpu_regfile_pkg::SR_DBG_PC && !debug_active_out
         |=> sysreg_access_error_out && !sysreg_rd_valid_out ##1 !sysreg_access_error_out;
   endproperty
   a_debug_gate: assert property (p_debug_gate)
      else $error("debug pair read outside window");

   property p_status_load;
      sysreg_load_instr_in && sysreg_sel_in == cpu_regfile_pkg::SR_STATUS && quiet
         |=> status_word_out == ($past(sysreg_load_data_in) & cpu_regfile_pkg::STATUS_MASK);
   endproperty
   a_status_load: assert property (p_status_load)
      else $error("status load not effective");

   c_nmi_then_return: cover property (nmi_take_in ##[1:20] interrupt_return_instr_in);
   c_maskable: cover property (maskable_take_in ##1 sysreg_store_instr_in);
   c_debug_read: cover property (debug_trap_instr_in ##[1:10] sysreg_rd_valid_out);

endmodule

// ### irq_ctl_model.sv
// Purpose: Interrupt controller model issuing take pulses
// Assumes: take is called just after a falling edge
// Notes:   Code bus is inverted once its take cycle is over
`timescale 1ns/1ps
module irq_ctl_model (
   input  wire logic        sys_clk_in,
   output logic             maskable_take_out,
   output logic             nmi_take_out,
   output logic      [31:0] exc_code_out
);
   // ------------------------------------------
   // Acceptance pulses
   // ------------------------------------------
   initial begin
      maskable_take_out = 1'b0;
      nmi_take_out = 1'b0;
      exc_code_out = 32'h0000_0000;
   end
   // Stale code never matches, so a late sample shows up
   task automatic take(input logic nmi, input logic [31:0] code);
      nmi_take_out = nmi;
      maskable_take_out = ~nmi;
      exc_code_out = code;
      @(negedge sys_clk_in);
      {nmi_take_out, maskable_take_out} = 2'b00;
      exc_code_out = ~code;
   endtask
endmodule

// ### cpu_regfile_tb.sv
// Purpose: Self-checking bench for the CPU register file
// Assumes: Inputs change at the falling edge
// Notes:   Reserved numbers are touched only to see them refused
`timescale 1ns/1ps
module cpu_regfile_tb;
   logic        sys_clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        gpr_wr_en_in, pc_load_en_in, pc_advance_en_in, status_wr_en_in;
   logic        sysreg_load_instr_in, sysreg_store_instr_in, interrupt_return_instr_in;
   logic        debug_trap_instr_in, debug_return_instr_in, maskable_take_in, nmi_take_in;
   logic        sysreg_rd_valid_out, sysreg_access_error_out, debug_active_out;
   logic [4:0]  gpr_rd_a_sel_in, gpr_rd_b_sel_in, gpr_wr_sel_in, sysreg_sel_in;
   logic [31:0] gpr_wr_data_in, pc_load_value_in, pc_advance_in, status_wr_in, exc_code_in;
   logic [31:0] sysreg_load_data_in, gpr_rd_a_out, gpr_rd_b_out, pc_out, status_word_out;
   logic [31:0] sysreg_rd_data_out, table_call_base_out;
   int          n_fail = 0;
   int          tests_run = 0;

   always #5 sys_clk_in = ~sys_clk_in;

   cpu_regfile u_dut (.sys_clk_in, .resetn_in, .gpr_rd_a_sel_in, .gpr_rd_b_sel_in, .gpr_wr_en_in,
      .gpr_wr_sel_in, .gpr_wr_data_in, .gpr_rd_a_out, .gpr_rd_b_out, .pc_load_en_in,
      .pc_load_value_in, .pc_advance_en_in, .pc_advance_in, .pc_out, .status_wr_en_in,
      .status_wr_in, .status_word_out, .sysreg_sel_in, .sysreg_load_instr_in,
      .sysreg_load_data_in, .sysreg_store_instr_in, .sysreg_rd_data_out, .sysreg_rd_valid_out,
      .sysreg_access_error_out, .maskable_take_in, .nmi_take_in, .exc_code_in,
      .interrupt_return_instr_in, .debug_trap_instr_in, .debug_return_instr_in,
      .debug_active_out, .table_call_base_out);
   irq_ctl_model u_irq (.sys_clk_in, .maskable_take_out(maskable_take_in),
      .nmi_take_out(nmi_take_in), .exc_code_out(exc_code_in));

   // ------------------------------------------
   // Helpers
   // ------------------------------------------
   task step; @(negedge sys_clk_in); endtask
   task clr;
      {gpr_wr_en_in, pc_load_en_in, pc_advance_en_in, status_wr_en_in} = '0;
      {sysreg_load_instr_in, sysreg_store_instr_in, interrupt_return_instr_in} = '0;
      {debug_trap_instr_in, debug_return_instr_in} = '0;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Request tasks idle one edge first: a strobe is never dropped and raised in one step
   task ld(input logic [4:0] n, input logic [31:0] d);
      step;
      sysreg_sel_in = n;
      sysreg_load_data_in = d;
      sysreg_load_instr_in = 1'b1;
      step;
      clr;
   endtask
   task st(input logic [4:0] n);
      step;
      sysreg_sel_in = n;
      sysreg_store_instr_in = 1'b1;
      step;
      clr;
   endtask
   task pc_set(input logic [31:0] v);
      step;
      pc_load_value_in = v;
      pc_load_en_in = 1'b1;
      step;
      clr;
   endtask
   task ret;
      step;
      interrupt_return_instr_in = 1'b1;
      step;
      clr;
   endtask
   task stop_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   // Back-to-back writes, the second aimed at the zero register
   task gpr_scn;
      gpr_wr_en_in = 1'b1;
      gpr_wr_sel_in = 5'h1F;
      gpr_wr_data_in = 32'hA5A5_0001;
      step;
      gpr_wr_sel_in = 5'h00;
      step;
      gpr_wr_sel_in = 5'h03;
      gpr_wr_data_in = 32'h5A5A_0003;
      step;
      clr;
      {gpr_rd_a_sel_in, gpr_rd_b_sel_in} = {5'h1F, 5'h03};
      step;
      chk(gpr_rd_a_out, 32'hA5A5_0001);
      chk(gpr_rd_b_out, 32'h5A5A_0003);
      gpr_rd_b_sel_in = 5'h00;
      step;
      chk(gpr_rd_b_out, 32'h0000_0000);
   endtask
   // Wrap at the top of the 64 MB space
   task pc_scn;
      pc_set(32'hFFFF_FFFF);
      chk(pc_out, 32'h03FF_FFFE);
      step;
      pc_advance_in = 32'h0000_0004;
      pc_advance_en_in = 1'b1;
      step;
      clr;
      chk(pc_out, 32'h0000_0002);
   endtask
   task sys_scn;
      static logic [4:0] nums [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h14};
      logic [31:0] ex;
      foreach (nums[i]) begin
         ld(nums[i], 32'hFFFF_FFFF);
         st(nums[i]);
         ex = (nums[i] inside {5'h00, 5'h02}) ? 32'h03FF_FFFF :
              (nums[i] inside {5'h01, 5'h03}) ? 32'h0000_00FF : 32'hFFFF_FFFF;
         chk(sysreg_rd_data_out, ex);
         chk({31'h0, sysreg_rd_valid_out}, 32'h1);
      end
      chk(table_call_base_out, 32'hFFFF_FFFF);
      ld(5'h05, 32'h0000_000F);
      chk(status_word_out, 32'h0000_000F);
      st(5'h06);
      chk({31'h0, sysreg_access_error_out}, 32'h1);
      chk(sysreg_rd_data_out, 32'h0000_0000);
      st(5'h15);
      chk({31'h0, sysreg_access_error_out}, 32'h1);
      st(5'h12);
      chk({31'h0, sysreg_access_error_out}, 32'h1);
   endtask
   // Maskable then NMI nested, then two returns unwinding
   task irq_scn;
      pc_set(32'h0000_0100);
      u_irq.take(1'b0, 32'h0000_0011);
      ld(5'h04, 32'hFFFF_FFFF);
      chk({31'h0, sysreg_access_error_out}, 32'h1);
      st(5'h04);
      chk(sysreg_rd_data_out, 32'h0000_0011);
      ld(5'h05, 32'h0000_0003);
      // Software copies the maskable saved PC out before nesting opens
      st(5'h00);
      chk(sysreg_rd_data_out, 32'h0000_0100);
      pc_set(32'h0000_0200);
      step;
      pc_load_value_in = 32'h0000_0300;
      pc_load_en_in = 1'b1;
      u_irq.take(1'b1, 32'h0000_0022);
      clr;
      chk(status_word_out, 32'h0000_0083);
      st(5'h00);
      chk(sysreg_rd_data_out, 32'h0000_0100);
      st(5'h01);
      chk(sysreg_rd_data_out, 32'h0000_000F);
      st(5'h02);
      chk(sysreg_rd_data_out, 32'h0000_0200);
      st(5'h04);
      chk(sysreg_rd_data_out, 32'h0000_0022);
      ld(5'h00, 32'h0000_0105);
      ret;
      chk(pc_out, 32'h0000_0200);
      chk(status_word_out, 32'h0000_0003);
      ret;
      chk(pc_out, 32'h0000_0104);
      chk(status_word_out, 32'h0000_000F);
   endtask
   task dbg_scn;
      step;
      debug_trap_instr_in = 1'b1;
      step;
      clr;
      chk({31'h0, debug_active_out}, 32'h1);
      st(5'h12);
      chk(sysreg_rd_data_out, 32'h0000_0104);
      step;
      debug_return_instr_in = 1'b1;
      step;
      clr;
      chk({31'h0, debug_active_out}, 32'h0);
   endtask

   // ------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------
   initial begin
      clr;
      {gpr_rd_a_sel_in, gpr_rd_b_sel_in, gpr_wr_sel_in, sysreg_sel_in} = '0;
      {gpr_wr_data_in, pc_load_value_in, pc_advance_in, status_wr_in} = '0;
      sysreg_load_data_in = '0;
      repeat (4) step;
      resetn_in = 1'b1;
      step;
      chk(status_word_out, 32'h0000_0020);
      gpr_scn;
      pc_scn;
      sys_scn;
      irq_scn;
      dbg_scn;
      stop_test;
   end
   initial begin
      #50000;
      n_fail++;
      stop_test;
   end
endmodule
